// file: rtl/lpg_pkg.sv
// package: constants and types for the low-power-off and gate-drive controller
package lpg_pkg;
  localparam int LPG_NSW = 4;
  localparam int LPG_MODE_W = 4;
  localparam int LPG_VSEL_W = 5;
  // index of the external-memory switcher; the others feed the processor domain
  localparam int LPG_MEM_SW = 3;
  // register offsets
  localparam logic [7:0] LPG_REG_MODE = 8'h00;
  localparam logic [7:0] LPG_REG_STBY = 8'h01;
  localparam logic [7:0] LPG_REG_LPO = 8'h02;
  localparam logic [7:0] LPG_REG_CTRL = 8'h03;
  localparam logic [7:0] LPG_REG_STAT = 8'h04;
  localparam logic [7:0] LPG_REG_VOUT = 8'h05;
  // field positions in LPG_REG_CTRL
  localparam int LPG_CTRL_PINV = 0;
  localparam int LPG_CTRL_SINV = 1;
  localparam int LPG_CTRL_GEN1 = 2;
  localparam int LPG_CTRL_GEN2 = 3;
  // both gate enables start set, so the drives stay low until software clears them
  localparam logic [31:0] LPG_CTRL_RESET = 32'h0000_000C;
  // ramp: one set point step every LPG_RAMP_CYC cycles
  localparam int LPG_RAMP_NS = 16;
  localparam int LPG_CLK_NS = 4;
  localparam int LPG_RAMP_CYC = (LPG_RAMP_NS + LPG_CLK_NS - 1) / LPG_CLK_NS;
  // operating modes
  typedef enum logic [2:0] {
    LPG_OFF, LPG_PWM, LPG_PWMPS, LPG_PFM, LPG_AUTO
  } lpg_op_t;
  // power states seen by this block
  typedef enum logic [3:0] {
    LPG_PS_OFF, LPG_PS_COLD, LPG_PS_WARM, LPG_PS_WDOG, LPG_PS_ON, LPG_PS_UOWAIT,
    LPG_PS_USEROFF, LPG_PS_MEMHOLD, LPG_PS_IMHCUT
  } lpg_pstate_t;
endpackage

// file: rtl/lpg_ctrl.sv
// module: switcher mode, set point and power-gate drive control
`timescale 1ns/1ps
`default_nettype none
module lpg_ctrl
  import lpg_pkg::*;
#(
  parameter int NSW = LPG_NSW
)(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic primary_standby_in_i,
  input wire logic secondary_standby_in_i,
  input wire lpg_pkg::lpg_pstate_t power_state_i,
  input wire logic [NSW-1:0] startup_slot_i,
  input wire logic [NSW*lpg_pkg::LPG_MODE_W-1:0] strap_mode_i,
  input wire logic [NSW*lpg_pkg::LPG_VSEL_W-1:0] strap_vsel_i,
  input wire logic strap_load_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  output logic [NSW*3-1:0] switcher_op_o,
  output logic [NSW*lpg_pkg::LPG_VSEL_W-1:0] switcher_vout_o,
  output logic core_gate_drive_o,
  output logic memory_gate_drive_o,
  output logic gate_pump_enable_o
);
  import lpg_pkg::*;

  localparam int MW = LPG_MODE_W;
  localparam int VW = LPG_VSEL_W;
  localparam int RW = $clog2(LPG_RAMP_CYC + 1);

  function automatic lpg_op_t normal_op(input logic [3:0] c);
    case (c)
      4'h1, 4'h5, 4'h6, 4'h9, 4'hD: normal_op = LPG_PWM;
      4'h2, 4'hA, 4'hB, 4'hE: normal_op = LPG_PWMPS;
      4'h3, 4'hF: normal_op = LPG_PFM;
      4'h4, 4'h8, 4'hC: normal_op = LPG_AUTO;
      default: normal_op = LPG_OFF;
    endcase
  endfunction

  function automatic lpg_op_t standby_op(input logic [3:0] c);
    case (c)
      4'h5: standby_op = LPG_PWM;
      4'h6, 4'h8, 4'hB: standby_op = LPG_AUTO;
      4'h9, 4'hA: standby_op = LPG_PWMPS;
      4'hC, 4'hD, 4'hE, 4'hF: standby_op = LPG_PFM;
      default: standby_op = LPG_OFF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [NSW*MW-1:0] switcher_mode_code;
  logic [NSW*VW-1:0] switcher_normal_setpoint;
  logic [NSW*VW-1:0] switcher_standby_setpoint;
  logic [NSW-1:0] switcher_memhold_mode_bit;
  logic [NSW-1:0] switcher_useroff_mode_bit;
  logic [31:0] ctrl;
  logic [NSW-1:0] retained;

  wire primary_standby_invert = ctrl[LPG_CTRL_PINV];
  wire secondary_standby_invert = ctrl[LPG_CTRL_SINV];
  wire [1:0] gate_drive_sw_enable = {ctrl[LPG_CTRL_GEN2], ctrl[LPG_CTRL_GEN1]};

  // strap loads the normal set point and copies it as the standby one
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      switcher_mode_code <= '0;
      switcher_normal_setpoint <= '0;
      switcher_standby_setpoint <= '0;
      switcher_memhold_mode_bit <= '0;
      switcher_useroff_mode_bit <= '0;
      ctrl <= LPG_CTRL_RESET;
    end
    else if (strap_load_i)
    begin
      switcher_mode_code <= strap_mode_i;
      switcher_normal_setpoint <= strap_vsel_i;
      switcher_standby_setpoint <= strap_vsel_i;
    end
    else if (reg_write_i)
    begin
      case (reg_addr_i)
        LPG_REG_MODE: switcher_mode_code <= reg_wdata_i[NSW*MW-1:0];
        LPG_REG_STBY: switcher_standby_setpoint <= reg_wdata_i[NSW*VW-1:0];
        LPG_REG_LPO:
        begin
          switcher_memhold_mode_bit <= reg_wdata_i[NSW-1:0];
          switcher_useroff_mode_bit <= reg_wdata_i[NSW+7:8];
        end
        LPG_REG_CTRL: ctrl <= {28'h0000000, reg_wdata_i[3:0]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby decode
  // no entry delay: the register alone sets the one-cycle lag
  logic standby;
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      standby <= 1'b0;
    else
      standby <= (primary_standby_in_i ^ primary_standby_invert) &
                 (secondary_standby_in_i ^ secondary_standby_invert);
  end

  ////////////////////////////////////////////////////////////////////////////
  // retention: set while in user off with the bit set, or in memory hold with the bit set for the LPG_MEM_SW switcher only, held
  // through the turn-on until the switcher's startup slot
  wire in_mh = (power_state_i == LPG_PS_MEMHOLD);
  wire in_uo = (power_state_i == LPG_PS_USEROFF);
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      retained <= '0;
    end
    else
    begin
      // a set outranks a slot, so a stray slot pulse cannot drop a held rail
      for (int i = 0; i < NSW; i++)
      begin
        if (in_mh)
          retained[i] <= switcher_memhold_mode_bit[i] & (i == LPG_MEM_SW);
        else if (in_uo)
          retained[i] <= switcher_useroff_mode_bit[i];
        else if (startup_slot_i[i])
          retained[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating mode and target set point per switcher
  logic [NSW*3-1:0] next_op;
  logic [NSW*VW-1:0] target;
  always_comb
  begin
    next_op = '0;
    target = '0;
    for (int i = 0; i < NSW; i++)
    begin
      if (retained[i])
      begin
        next_op[i*3 +: 3] = LPG_PFM;
        target[i*VW +: VW] = switcher_standby_setpoint[i*VW +: VW];
      end
      else if (in_mh || in_uo)
      begin
        next_op[i*3 +: 3] = LPG_OFF;
        target[i*VW +: VW] = switcher_normal_setpoint[i*VW +: VW];
      end
      else if (standby)
      begin
        next_op[i*3 +: 3] = standby_op(switcher_mode_code[i*MW +: MW]);
        target[i*VW +: VW] = switcher_standby_setpoint[i*VW +: VW];
      end
      else
      begin
        next_op[i*3 +: 3] = normal_op(switcher_mode_code[i*MW +: MW]);
        target[i*VW +: VW] = switcher_normal_setpoint[i*VW +: VW];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      switcher_op_o <= '0;
    else
      switcher_op_o <= next_op;
  end

  ////////////////////////////////////////////////////////////////////////////
  // set point ramp: one code step per tick keeps the output slope bounded
  logic [RW-1:0] ramp_cnt;
  wire ramp_tick = (ramp_cnt == '0);
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      ramp_cnt <= '0;
    else if (ramp_tick)
      ramp_cnt <= RW'(LPG_RAMP_CYC - 1);
    else
      ramp_cnt <= ramp_cnt - RW'(1);
  end

  // a strap load jumps straight to the strap value: the rail is not up yet then
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      switcher_vout_o <= '0;
    else
    begin
      for (int i = 0; i < NSW; i++)
      begin
        if (strap_load_i)
          switcher_vout_o[i*VW +: VW] <= strap_vsel_i[i*VW +: VW];
        else if (ramp_tick && switcher_vout_o[i*VW +: VW] < target[i*VW +: VW])
          switcher_vout_o[i*VW +: VW] <= switcher_vout_o[i*VW +: VW] + VW'(1);
        else if (ramp_tick && switcher_vout_o[i*VW +: VW] > target[i*VW +: VW])
          switcher_vout_o[i*VW +: VW] <= switcher_vout_o[i*VW +: VW] - VW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate drives: only software may close the switches, and only in the
  // software-controlled states; the device never raises them on its own
  // after reset both drives stay low in every state until a host write
  wire sw_ctl = (power_state_i == LPG_PS_WDOG) || (power_state_i == LPG_PS_ON) ||
                (power_state_i == LPG_PS_UOWAIT);
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      core_gate_drive_o <= 1'b0;
      memory_gate_drive_o <= 1'b0;
      gate_pump_enable_o <= 1'b0;
    end
    else
    begin
      core_gate_drive_o <= sw_ctl & ~gate_drive_sw_enable[0];
      memory_gate_drive_o <= sw_ctl & ~gate_drive_sw_enable[1];
      gate_pump_enable_o <= sw_ctl & ~(&gate_drive_sw_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read, data one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= '0;
    else if (reg_read_i)
    begin
      case (reg_addr_i)
        LPG_REG_MODE: reg_rdata_o <= 32'(switcher_mode_code);
        LPG_REG_STBY: reg_rdata_o <= 32'(switcher_standby_setpoint);
        LPG_REG_LPO: reg_rdata_o <= 32'({switcher_useroff_mode_bit, 4'h0,
                                         switcher_memhold_mode_bit});
        LPG_REG_CTRL: reg_rdata_o <= ctrl;
        LPG_REG_STAT: reg_rdata_o <= 32'({retained, standby});
        LPG_REG_VOUT: reg_rdata_o <= 32'(switcher_vout_o);
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_o <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on what this block drives; the set point ones other than chk_strap_copy look
  // at switcher 0 only, since every switcher shares the same logic
  chk_gate_low_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (in_mh || in_uo) |=> (!core_gate_drive_o && !memory_gate_drive_o))
    else $error("gate drive high in low-power-off");
  chk_gate_follow_en: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sw_ctl && !gate_drive_sw_enable[0]) |=> core_gate_drive_o)
    else $error("core gate drive not high with enable 0");
  chk_gate_en_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!sw_ctl || gate_drive_sw_enable[1]) |=> !memory_gate_drive_o)
    else $error("memory gate drive high when it must be low");
  chk_pump_off_both: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sw_ctl && &gate_drive_sw_enable) |=> !gate_pump_enable_o)
    else $error("pump on with both enables set");
  chk_standby_and: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (primary_standby_in_i ^ primary_standby_invert) !=
    (secondary_standby_in_i ^ secondary_standby_invert) |=> !standby)
    else $error("standby with only one input active");
  chk_retain_pfm: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    retained[0] |=> switcher_op_o[2:0] == 3'(LPG_PFM))
    else $error("retained switcher not in PFM");
  chk_memhold_core_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    in_mh ##1 in_mh |=> switcher_op_o[2:0] == 3'(LPG_OFF))
    else $error("processor switcher on in memory hold");
  chk_ramp_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !strap_load_i |=> ($past(switcher_vout_o[VW-1:0]) - switcher_vout_o[VW-1:0] <= 5'h01 ||
                       switcher_vout_o[VW-1:0] - $past(switcher_vout_o[VW-1:0]) <= 5'h01))
    else $error("set point jumped more than one step");
  chk_gate_mem_on: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sw_ctl && !gate_drive_sw_enable[1]) |=> memory_gate_drive_o)
    else $error("memory gate drive not high with enable 0");
  chk_gate_core_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !sw_ctl |=> !core_gate_drive_o)
    else $error("core gate drive high outside software states");
  chk_gate_cut_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (power_state_i == LPG_PS_IMHCUT) |=> (!core_gate_drive_o && !memory_gate_drive_o))
    else $error("gate drive high in power cut");
  chk_pump_on_one: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sw_ctl && !(&gate_drive_sw_enable)) |=> gate_pump_enable_o)
    else $error("pump off with an enable clear");
  chk_strap_copy: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    strap_load_i |=> (switcher_standby_setpoint == switcher_normal_setpoint))
    else $error("standby set point differs from strap value");
  chk_mode_kept: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!strap_load_i && !reg_write_i) |=> $stable(switcher_mode_code))
    else $error("mode code changed without a write");
  chk_retain_target: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    retained[0] |-> (target[VW-1:0] == switcher_standby_setpoint[VW-1:0]))
    else $error("retained switcher not aimed at standby set point");
  chk_memhold_retain: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    in_mh |=> (retained[LPG_MEM_SW] == $past(switcher_memhold_mode_bit[LPG_MEM_SW])))
    else $error("memory switcher retention does not follow its bit");
  chk_useroff_retain: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    in_uo |=> (retained == $past(switcher_useroff_mode_bit)))
    else $error("user off retention does not follow the bits");
  chk_slot_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!in_mh && !in_uo && startup_slot_i[0]) |=> !retained[0])
    else $error("retention kept past the startup slot");
  chk_standby_point: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (standby && !retained[0] && !in_mh && !in_uo) |->
    (target[VW-1:0] == switcher_standby_setpoint[VW-1:0]))
    else $error("standby does not select the standby set point");
  chk_invert_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (primary_standby_invert && primary_standby_in_i) |=> !standby)
    else $error("inverted primary input high still gives standby");
endmodule // lpg_ctrl
`default_nettype wire

// file: tb/lpg_host_model.sv
// host software model: master of the register port
`timescale 1ns/1ps
`default_nettype none
module lpg_host_model
  import lpg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [31:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_write_o,
  output logic reg_read_o
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 32'h0;
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
  end
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_write_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_o <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so take them there
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_o <= 1'b0;
    #1;
    v = reg_rdata_i;
  endtask
  // gates close on this request, or on any write clearing the enables, in the software-controlled states
  task automatic close_gates();
    wr(LPG_REG_CTRL, 32'h0);
  endtask
endmodule // lpg_host_model
`default_nettype wire

// file: tb/test_lpg_ctrl.sv
// testbench: gate drive, standby decode, switcher modes and retention
`timescale 1ns/1ps
`default_nettype none
module test_lpg_ctrl;
  import lpg_pkg::*;
  localparam logic [15:0] SM = 16'hF185;
  localparam logic [19:0] SV = {5'h1F, 5'h05, 5'h10, 5'h0A};
  localparam logic [19:0] SB = {5'h02, 5'h03, 5'h04, 5'h12};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ps = 1'b0;
  logic pss = 1'b0;
  logic sload = 1'b0;
  logic [3:0] slot = 4'h0;
  lpg_pstate_t st = LPG_PS_OFF;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic we, re, g1, g2, pump;
  logic [11:0] op;
  logic [19:0] vout;
  int err_total = 0;
  int comparisons = 0;
  // rows: power state and whether software owns the gate drives there
  lpg_pstate_t row_st[9] = '{LPG_PS_OFF, LPG_PS_COLD, LPG_PS_WARM, LPG_PS_WDOG,
    LPG_PS_ON, LPG_PS_UOWAIT, LPG_PS_USEROFF, LPG_PS_MEMHOLD, LPG_PS_IMHCUT};
  logic row_sw[9] = '{0, 0, 0, 1, 1, 1, 0, 0, 0};
  // rows: mode code to normal and standby behaviour
  lpg_op_t tab_norm[16] = '{LPG_OFF, LPG_PWM, LPG_PWMPS, LPG_PFM, LPG_AUTO, LPG_PWM, LPG_PWM,
    LPG_OFF, LPG_AUTO, LPG_PWM, LPG_PWMPS, LPG_PWMPS, LPG_AUTO, LPG_PWM, LPG_PWMPS, LPG_PFM};
  lpg_op_t tab_stby[16] = '{LPG_OFF, LPG_OFF, LPG_OFF, LPG_OFF, LPG_OFF, LPG_PWM, LPG_AUTO,
    LPG_OFF, LPG_AUTO, LPG_PWMPS, LPG_PWMPS, LPG_AUTO, LPG_PFM, LPG_PFM, LPG_PFM, LPG_PFM};
  always #2 clk = ~clk;
  lpg_host_model h (.clk_sys_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_write_o(we), .reg_read_o(re));
  lpg_ctrl dut (.clk_sys_i(clk), .reset_i(rst), .primary_standby_in_i(ps),
    .secondary_standby_in_i(pss), .power_state_i(st), .startup_slot_i(slot),
    .strap_mode_i(SM), .strap_vsel_i(SV), .strap_load_i(sload), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata),
    .switcher_op_o(op), .switcher_vout_o(vout), .core_gate_drive_o(g1),
    .memory_gate_drive_o(g2), .gate_pump_enable_o(pump));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    h.rd(a, d);
    chk(d, exp);
  endtask
  task automatic ops(input lpg_op_t o0, o1, o2, o3);
    chk(op, {o3, o2, o1, o0});
  endtask
  task automatic go(input lpg_pstate_t s);
    @(posedge clk);
    st <= s;
    cyc(3);
  endtask
  task automatic pins(input logic p, input logic s);
    @(posedge clk);
    ps <= p;
    pss <= s;
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({op, g1, g2, pump}, 0);
    @(posedge clk);
    sload <= 1'b1;
    @(posedge clk);
    sload <= 1'b0;
    rdc(LPG_REG_STBY, SV);
    rdc(LPG_REG_MODE, SM);
    chk(vout, SV);
    for (int r = 0; r < 9; r++)
      for (int e = 0; e < 4; e++)
      begin
        @(posedge clk);
        st <= row_st[r];
        h.wr(LPG_REG_CTRL, 32'(e) << 2);
        cyc(3);
        chk(g1, row_sw[r] & !e[0]);
        chk(g2, row_sw[r] & !e[1]);
        if (row_sw[r])
          chk(pump, e != 3);
      end
    @(posedge clk);
    st <= LPG_PS_ON;
    for (int k = 0; k < 16; k++)
    begin
      pins(k[3], k[2]);
      h.wr(LPG_REG_CTRL, 32'(k[1:0]));
      cyc(3);
      h.rd(LPG_REG_STAT, d);
      chk(d[0], (k[3] ^ k[0]) & (k[2] ^ k[1]));
    end
    h.wr(LPG_REG_CTRL, 32'h0);
    pins(0, 0);
    h.wr(LPG_REG_MODE, 32'h6185);
    h.wr(LPG_REG_STBY, {12'h0, SB});
    rdc(LPG_REG_MODE, 32'h6185);
    cyc(2);
    ops(LPG_PWM, LPG_AUTO, LPG_PWM, LPG_PWM);
    pins(1, 1);
    cyc(6);
    // a step straight to the standby point would already be past this bound
    chk(vout[4:0] < 5'h0E, 1);
    ops(LPG_PWM, LPG_AUTO, LPG_OFF, LPG_AUTO);
    rdc(LPG_REG_MODE, 32'h6185);
    cyc(200);
    chk(vout[4:0], 5'h12);
    pins(0, 1);
    cyc(3);
    ops(LPG_PWM, LPG_AUTO, LPG_PWM, LPG_PWM);
    cyc(200);
    chk(vout[4:0], 5'h0A);
    h.wr(8'hF0, 32'hFFFF_FFFF);
    rdc(8'hF0, 32'h0);
    rdc(LPG_REG_MODE, 32'h6185);
    for (int c = 0; c < 16; c++)
    begin
      h.wr(LPG_REG_MODE, {16'h0, {4{4'(c)}}});
      cyc(2);
      chk(op, {4{tab_norm[c]}});
      pins(1, 1);
      cyc(2);
      chk(op, {4{tab_stby[c]}});
      pins(0, 1);
    end
    h.wr(LPG_REG_MODE, 32'h6185);
    h.wr(LPG_REG_LPO, 32'h0509);
    go(LPG_PS_USEROFF);
    ops(LPG_PFM, LPG_OFF, LPG_PFM, LPG_OFF);
    cyc(200);
    chk(vout[14:0], {5'h03, 5'h10, 5'h12});
    go(LPG_PS_ON);
    chk({op[8:6], op[2:0], vout[4:0]}, {LPG_PFM, LPG_PFM, 5'h12});
    @(posedge clk);
    slot <= 4'h1;
    @(posedge clk);
    slot <= 4'h0;
    cyc(3);
    chk(op[2:0], LPG_PWM);
    chk(op[8:6], LPG_PFM);
    cyc(200);
    chk(vout[4:0], 5'h0A);
    h.close_gates();
    cyc(3);
    chk({g1, g2}, 2'b11);
    go(LPG_PS_MEMHOLD);
    ops(LPG_OFF, LPG_OFF, LPG_OFF, LPG_PFM);
    chk({g1, g2}, 2'b00);
    cyc(200);
    chk(vout[19:15], 5'h02);
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    chk({op, g1, g2, pump}, 0);
    @(posedge clk);
    rst <= 1'b0;
    rdc(LPG_REG_MODE, 32'h0);
    go(LPG_PS_ON);
    chk({g1, g2, pump}, 3'b000);
    h.close_gates();
    cyc(3);
    chk({g1, g2, pump}, 3'b111);
    complete_run();
  end
  // the whole run needs well under 5000 cycles
  initial
  begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // test_lpg_ctrl
`default_nettype wire
